// ===== inc/fbv_pkg.sv
/*
 * Shared constants and types of the finder board control logic: register
 * offsets, control bit positions, bus address modifiers, wait times, the
 * pin bundles and the error record with its update function.
 * Assumes a single 100 MHz clock domain for all users of this package.
 */
package fbv_pkg;

    localparam int CLK_PERIOD_NS = 10;
    // Least time that an on-board chip needs to answer a bus access.
    localparam int EXT_WAIT_NS   = 100;
    localparam logic [3:0] EXT_WAIT_CYC =
        4'((EXT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] LOCAL_WAIT_CYC = 4'h2;
    localparam logic [3:0] CHIP_STROBE_AT = 4'h2;

    localparam logic [5:0] AM_A32_SINGLE = 6'h09;
    localparam logic [5:0] AM_A32_BLOCK  = 6'h0b;
    localparam logic [2:0] GA_PAD        = 3'h0;

    localparam logic [3:0] REG_LOCAL     = 4'h0;
    localparam logic [3:0] REG_IDSTORE   = 4'h1;
    localparam logic [3:0] REG_EXT_FIRST = 4'h2;
    localparam logic [3:0] REG_HDRBUF    = 4'h5;

    localparam logic [7:0] OFS_DIAG   = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_DEPTH  = 8'h08;
    localparam logic [7:0] OFS_AW0    = 8'h10;
    localparam logic [7:0] OFS_AB0    = 8'h14;
    localparam logic [7:0] OFS_FW0    = 8'h18;
    localparam logic [7:0] OFS_FB0    = 8'h1c;
    localparam logic [7:0] OFS_CLKDLY = 8'h20;

    localparam int B_SWRST  = 31;
    localparam int B_SWCLK  = 30;
    localparam int B_CLKSEL = 29;
    localparam int B_ALOOP  = 28;
    localparam int B_APROG  = 27;
    localparam int B_ARST   = 26;
    localparam int B_FPROG1 = 24;
    localparam int B_FPROG2 = 23;
    localparam int B_FRST   = 22;
    localparam int B_FLOOP  = 21;
    localparam int B_PPROG  = 20;
    localparam int B_PRST   = 19;
    localparam int B_PLOOP  = 18;
    localparam int B_NOHALT = 17;
    localparam int B_ACLR   = 16;
    localparam int B_FCLR   = 15;
    localparam int B_FLASH  = 14;
    localparam int B_MASK   = 13;
    localparam int DONE_W   = 10;
    localparam int BYTE_LO  = 24;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] CTRL_RO_MASK = 32'h0000_0fff;
    localparam logic [31:0] LOOP_MASK    = 32'h1024_0000;
    localparam logic [7:0]  CNT_MAX      = 8'hff;

    typedef struct packed {
        logic [31:2] addr;
        logic [5:0]  am;
        logic [4:0]  ga;
        logic        asN;
        logic        ds0N;
        logic        ds1N;
        logic        writeN;
        logic        lwordN;
        logic [31:0] data;
    } fbv_vme_in_type;

    typedef struct packed {
        logic [DONE_W-1:0] done;
        logic              globalReset;
        logic              haltN;
        logic              beamSync;
        logic [2:0]        ticks;
        logic [13:0]       alignW0;
        logic [13:0]       alignB0;
        logic [7:0]        finderW0;
        logic [7:0]        finderB0;
        logic [31:0]       chipRdData;
    } fbv_sys_in_type;

    typedef struct packed {
        logic [15:0] chipSel;
        logic [19:2] chipAddr;
        logic        chipWrStrobe;
        logic        chipRead;
        logic [31:0] chipWrData;
    } fbv_chip_out_type;

    typedef struct packed {
        logic [7:0]  count;
        logic [23:0] flags;
    } fbv_err_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_ACK  = 3'b100
    } fbv_state_type;

    // A hit in the clearing cycle is kept, so that clear loses no error; the count stops at CNT_MAX.
    function automatic fbv_err_type fbv_err_next(input fbv_err_type cur,
                                                 input logic [23:0] hits,
                                                 input logic        clr);
        fbv_err_type n;
        n = clr ? '0 : cur;
        n.flags = n.flags | hits;
        if (|hits && n.count != CNT_MAX) begin
            n.count = n.count + 8'h01;
        end
        return n;
    endfunction : fbv_err_next

endpackage : fbv_pkg

// ===== hw/fbv_identity_store.sv
/*
 * Identity store: 32 ASCII characters, a serial digit, a three character
 * board type code and a module description, one character per read.
 * Assumes the index is stable for one clock before the character is used.
 */
module fbv_identity_store import fbv_pkg::*; #(
    parameter logic [3:0]     SERIAL_NUM = 4'h1,
    // Arbitrary type code; the real one is assigned per board type.
    parameter logic [23:0]    TYPE_CODE  = "TY0",
    parameter logic [223:0]   DESC       = "Track Segment Finder Ver 4.0"
) (
    input  wire logic       mclk,
    input  wire logic       rstN,
    input  wire logic [4:0] index,
    output logic      [7:0] idChar
);

    function automatic logic [7:0] romChar(input logic [4:0] i);
        logic [255:0] image;
        image = {(SERIAL_NUM < 4'ha) ? 8'h30 + 8'(SERIAL_NUM)
                                     : 8'h37 + 8'(SERIAL_NUM),
                 TYPE_CODE, DESC};
        return image[(5'd31 - i) * 8 +: 8];
    endfunction : romChar

    logic [7:0] next_idChar;

    always_comb begin
        next_idChar = romChar(index);
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            idChar <= 8'h00;
        end else begin
            idChar <= next_idChar;
        end
    end

endmodule : fbv_identity_store

// ===== hw/fbv_board_control.sv
/*
 * Finder board control: bus target decoder for the crate bus, control,
 * diagnostic, depth and clock delay registers, error records, loop-mode
 * gating and staging, ready indicator and second level header word.
 * Assumes bus and board pins are asynchronous to mclk, and that the three
 * slice clocks arrive as slow square waves that mclk can sample.
 */
// Operation
// - Only 32-bit aligned single or block transfers are answered.
// - Only extended 32-bit addressing reaches the board.
// - Address modifiers 09 and 0B only; all others ignored.
// - Selected only when address, modifier and geographical address match.
// - When region 2 or up is selected, except for the header beat, drive chip selects, address, write strobe and read control.
// - Control bits 11 to 2 read back every chip's done signal.
// - Ready is the AND of all done signals and lights the green lamp.
// - Global reset, halt and beam sync also steer the loop outputs.
// - Loop outputs are re-registered on the 33, 66 and 132 ns clocks.
// - Control bit 31 is a software reset clearing the loop bits.
// - Bit 28 pumps alignment data in a loop, else its RAM is bus reachable.
// - Bit 21 loops the finder section, bit 18 the pixel section.
// - Bits 26, 22 and 19 reset alignment, finder and pixel sections.
// - Bits 27, 24, 23 and 20 force reprogramming of their chip groups.
// - Bit 17 lets loop tests start without the global halt.
// - Bits 16 and 15 clear alignment and finder error records.
// - Bit 14 enables bus flash programming, bit 13 masks error reporting.
// - Bit 30 is a software clock, bit 29 selects it for the chips.
// - Word-zero and beam-zero errors are latched and counted.
// - An 8-bit register sets the experiment clock delay line.
// - First word of a level 2 read is a header with type, serial, address, depth.
// - The identity store holds 32 ASCII characters: serial, type, description.
// - Section reset bits reset the flip-flops inside those chips.
module fbv_board_control import fbv_pkg::*; #(
    parameter logic [3:0] SERIAL_NUM = 4'h1,
    // Arbitrary board type value for the header word.
    parameter logic [7:0] BOARD_TYPE = 8'h5a
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire fbv_vme_in_type   vmeIn,
    input  wire fbv_sys_in_type   sysIn,
    output logic           [31:0] vmeDataOut,
    output logic                  vmeDataOe,
    output logic                  vmeDtackN,
    output logic                  vmeDtackOe,
    output fbv_chip_out_type      chipOut,
    output logic                  alignLoop,
    output logic                  finderLoop,
    output logic                  pixelLoop,
    output logic                  alignReset,
    output logic                  finderReset,
    output logic                  pixelReset,
    output logic            [3:0] forceProgram,
    output logic                  flashProgEnable,
    output logic                  alignRamBusAccess,
    output logic                  swClock,
    output logic                  clockSelect,
    output logic            [7:0] clockDelay,
    output logic                  readyLed,
    output logic                  errorFlag
);

    ////////////////////////////////////////////////////////////////////////
    logic           rstMeta, rstN;
    fbv_vme_in_type vmeMeta, vme;
    fbv_sys_in_type sysMeta, sys;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            vmeMeta <= '1;
            vme     <= '1;
            sysMeta <= '0;
            sys     <= '0;
        end else begin
            vmeMeta <= vmeIn;
            vme     <= vmeMeta;
            sysMeta <= sysIn;
            sys     <= sysMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    fbv_state_type state, next_state;
    logic [3:0]    waitCnt, next_waitCnt;
    logic [31:2]   accAddr, next_accAddr;
    logic [31:0]   wrData, next_wrData, next_vmeDataOut;
    logic          firstBeat, next_firstBeat, blockLive, next_blockLive;
    logic          isWrite, next_isWrite, hdrBeat, next_hdrBeat;
    logic          next_vmeDataOe, next_vmeDtackOe;
    logic [31:0]   ctrl, next_ctrl, diag, next_diag;
    logic [7:0]    depth, next_depth, clkDly, next_clkDly, idChar;
    logic          dsActive, amOk, boardHit, startAcc, extCycle, lastWait;
    logic [31:2]   useAddr;
    logic [3:0]    region;
    logic [31:0]   rdLocal, rdData, header;
    fbv_err_type   err [4];

    assign dsActive = !vme.asN && !vme.ds0N && !vme.ds1N && !vme.lwordN;
    assign amOk     = vme.am == AM_A32_SINGLE || vme.am == AM_A32_BLOCK;
    assign boardHit = amOk && vme.addr[31:24] == {GA_PAD, vme.ga};
    assign startAcc = state == ST_IDLE && dsActive
                      && (firstBeat ? boardHit : blockLive);
    // Block transfers carry the address only once; later beats count on.
    assign useAddr  = firstBeat ? vme.addr : accAddr + 30'h1;
    assign region   = accAddr[23:20];
    assign extCycle = region >= REG_EXT_FIRST && !hdrBeat;
    assign lastWait = state == ST_WAIT && waitCnt == 4'h1;
    assign header   = {depth, BOARD_TYPE, 4'h0, SERIAL_NUM, GA_PAD, vme.ga};

    always_comb begin
        rdLocal = 32'h0000_0000;
        if (accAddr[19:8] == '0) begin
            case ({accAddr[7:2], 2'b00})
                OFS_DIAG:   rdLocal = diag;
                OFS_CTRL:   rdLocal = {ctrl[31:12], sys.done, readyLed, errorFlag};
                OFS_DEPTH:  rdLocal = {depth, 24'h0};
                OFS_AW0:    rdLocal = err[0];
                OFS_AB0:    rdLocal = err[1];
                OFS_FW0:    rdLocal = err[2];
                OFS_FB0:    rdLocal = err[3];
                OFS_CLKDLY: rdLocal = {clkDly, 24'h0};
                default:    rdLocal = 32'h0000_0000;
            endcase
        end
        if (hdrBeat) begin
            rdData = header;
        end else if (region == REG_LOCAL) begin
            rdData = rdLocal;
        end else if (region == REG_IDSTORE) begin
            rdData = {idChar, 24'h0};
        end else if (extCycle) begin
            rdData = sys.chipRdData;
        end else begin
            rdData = 32'h0000_0000;
        end
    end

    fbv_identity_store #(
        .SERIAL_NUM (SERIAL_NUM)
    ) u_fbv_identity_store (
        .mclk   (mclk),
        .rstN   (rstN),
        .index  (accAddr[6:2]),
        .idChar (idChar)
    );

    always_comb begin
        next_state      = state;
        next_waitCnt    = waitCnt;
        next_accAddr    = accAddr;
        next_wrData     = wrData;
        next_firstBeat  = firstBeat;
        next_blockLive  = blockLive;
        next_isWrite    = isWrite;
        next_hdrBeat    = hdrBeat;
        next_vmeDataOut = vmeDataOut;
        next_vmeDataOe  = vmeDataOe;
        next_vmeDtackOe = vmeDtackOe;
        next_ctrl       = ctrl;
        next_diag       = diag;
        next_depth      = depth;
        next_clkDly     = clkDly;
        unique case (state)
            ST_IDLE: begin
                if (vme.asN) begin
                    next_firstBeat = 1'b1;
                    next_blockLive = 1'b0;
                end
                if (startAcc) begin
                    next_state     = ST_WAIT;
                    next_accAddr   = useAddr;
                    next_wrData    = vme.data;
                    next_isWrite   = !vme.writeN;
                    next_blockLive = vme.am == AM_A32_BLOCK;
                    next_hdrBeat   = firstBeat && !vme.writeN == 1'b0
                                     && useAddr[23:20] == REG_HDRBUF;
                    next_waitCnt   = useAddr[23:20] >= REG_EXT_FIRST
                                     ? EXT_WAIT_CYC : LOCAL_WAIT_CYC;
                end
            end
            ST_WAIT: begin
                next_waitCnt = waitCnt - 4'h1;
                if (lastWait) begin
                    next_state      = ST_ACK;
                    next_vmeDtackOe = 1'b1;
                    next_vmeDataOe  = !isWrite;
                    next_vmeDataOut = isWrite ? vmeDataOut : rdData;
                    next_firstBeat  = 1'b0;
                    if (isWrite && region == REG_LOCAL && accAddr[19:8] == '0) begin
                        case ({accAddr[7:2], 2'b00})
                            OFS_DIAG:   next_diag   = wrData;
                            OFS_CTRL:   next_ctrl   = wrData & ~CTRL_RO_MASK;
                            OFS_DEPTH:  next_depth  = wrData[BYTE_LO +: 8];
                            OFS_CLKDLY: next_clkDly = wrData[BYTE_LO +: 8];
                            default:    next_diag   = diag;
                        endcase
                    end
                end
            end
            ST_ACK: begin
                if (vme.ds0N && vme.ds1N) begin
                    next_state      = ST_IDLE;
                    next_vmeDtackOe = 1'b0;
                    next_vmeDataOe  = 1'b0;
                end
            end
        endcase
        if (next_ctrl[B_SWRST]) begin
            next_ctrl = next_ctrl & ~LOOP_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state      <= ST_IDLE;
            waitCnt    <= 4'h0;
            accAddr    <= '0;
            wrData     <= 32'h0000_0000;
            firstBeat  <= 1'b1;
            blockLive  <= 1'b0;
            isWrite    <= 1'b0;
            hdrBeat    <= 1'b0;
            vmeDataOut <= 32'h0000_0000;
            vmeDataOe  <= 1'b0;
            vmeDtackOe <= 1'b0;
            ctrl       <= CTRL_RESET;
            diag       <= 32'h0000_0000;
            depth      <= 8'h00;
            clkDly     <= 8'h00;
        end else begin
            state      <= next_state;
            waitCnt    <= next_waitCnt;
            accAddr    <= next_accAddr;
            wrData     <= next_wrData;
            firstBeat  <= next_firstBeat;
            blockLive  <= next_blockLive;
            isWrite    <= next_isWrite;
            hdrBeat    <= next_hdrBeat;
            vmeDataOut <= next_vmeDataOut;
            vmeDataOe  <= next_vmeDataOe;
            vmeDtackOe <= next_vmeDtackOe;
            ctrl       <= next_ctrl;
            diag       <= next_diag;
            depth      <= next_depth;
            clkDly     <= next_clkDly;
        end
    end

    // Open-drain acknowledge: the level is always low, only the enable moves.
    assign vmeDtackN = 1'b0;

    always_comb begin
        chipOut = '0;
        chipOut.chipAddr   = accAddr[19:2];
        chipOut.chipWrData = wrData;
        if (state == ST_WAIT && extCycle) begin
            chipOut.chipSel[region] = 1'b1;
            chipOut.chipRead        = !isWrite;
            chipOut.chipWrStrobe    = isWrite && waitCnt == CHIP_STROBE_AT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [43:0] hitPrev, hitNow;
    logic [2:0]  armed, started, next_started, stage, next_stage, tickPrev;
    logic        beamPrev, beamRise, next_readyLed, next_errorFlag;
    logic [2:0]  tickRise;
    fbv_err_type next_err [4];

    assign hitNow   = {sys.alignW0, sys.alignB0, sys.finderW0, sys.finderB0};
    assign beamRise = sys.beamSync && !beamPrev;
    assign tickRise = sys.ticks & ~tickPrev;

    always_comb begin
        next_err[0] = fbv_err_next(err[0], {10'h0, sys.alignW0 & ~hitPrev[43:30]},
                                   ctrl[B_ACLR]);
        next_err[1] = fbv_err_next(err[1], {10'h0, sys.alignB0 & ~hitPrev[29:16]},
                                   ctrl[B_ACLR]);
        next_err[2] = fbv_err_next(err[2], {16'h0, sys.finderW0 & ~hitPrev[15:8]},
                                   ctrl[B_FCLR]);
        next_err[3] = fbv_err_next(err[3], {16'h0, sys.finderB0 & ~hitPrev[7:0]},
                                   ctrl[B_FCLR]);
        // Halt is active low; bit 17 stands in for it during bench tests.
        armed = {ctrl[B_PLOOP], ctrl[B_FLOOP], ctrl[B_ALOOP]}
                & {3{!sys.globalReset && (!sys.haltN || ctrl[B_NOHALT])}};
        next_started = armed & (started | {3{beamRise}});
        for (int i = 0; i < 3; i++) begin
            next_stage[i] = tickRise[i] ? started[i] : stage[i];
        end
        next_readyLed  = &sys.done;
        next_errorFlag = |{err[0].flags, err[1].flags, err[2].flags, err[3].flags}
                         && !ctrl[B_MASK];
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < 4; i++) begin
                err[i] <= '0;
            end
            hitPrev   <= '0;
            beamPrev  <= 1'b0;
            tickPrev  <= 3'h0;
            started   <= 3'h0;
            stage     <= 3'h0;
            readyLed  <= 1'b0;
            errorFlag <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                err[i] <= next_err[i];
            end
            hitPrev   <= hitNow;
            beamPrev  <= sys.beamSync;
            tickPrev  <= sys.ticks;
            started   <= next_started;
            stage     <= next_stage;
            readyLed  <= next_readyLed;
            errorFlag <= next_errorFlag;
        end
    end

    // Stage 0 follows the 132 ns clock, stage 1 the 66 ns, stage 2 the 33 ns.
    assign alignLoop         = stage[0];
    assign finderLoop        = stage[1];
    assign pixelLoop         = stage[2];
    assign alignReset        = ctrl[B_ARST];
    assign finderReset       = ctrl[B_FRST];
    assign pixelReset        = ctrl[B_PRST];
    assign forceProgram      = {ctrl[B_APROG], ctrl[B_FPROG1],
                                ctrl[B_FPROG2], ctrl[B_PPROG]};
    assign flashProgEnable   = ctrl[B_FLASH];
    assign alignRamBusAccess = !ctrl[B_ALOOP];
    assign swClock           = ctrl[B_SWCLK];
    assign clockSelect       = ctrl[B_CLKSEL];
    assign clockDelay        = clkDly;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstN);

    AST_AM_FILTER: assert property (
        state == ST_IDLE && firstBeat && dsActive && !amOk |=> state == ST_IDLE)
        else $error("cycle with foreign modifier was answered");
    AST_SELECT: assert property (
        state == ST_IDLE && firstBeat && $past(state) == ST_IDLE
        ##1 state == ST_WAIT |-> $past(boardHit))
        else $error("access started without a board match");
    AST_WAIT_BOUND: assert property (
        $rose(state == ST_WAIT) |-> ##[1:12] vmeDtackOe)
        else $error("no acknowledge within the wait bound");
    AST_STROBE: assert property (
        chipOut.chipWrStrobe |-> !chipOut.chipRead && |chipOut.chipSel
        && $past(state) == ST_WAIT)
        else $error("write strobe without chip select");
    AST_READY: assert property (
        &sys.done ##1 &sys.done |-> readyLed)
        else $error("ready lamp dark with all chips loaded");
    AST_SWRESET: assert property (
        ctrl[B_SWRST] |-> (ctrl & LOOP_MASK) == 32'h0 ##1 started == 3'h0)
        else $error("software reset left a loop bit set");
    AST_LOOP_GATE: assert property (
        sys.globalReset |=> started == 3'h0 ##1 stage[0] == 1'b0 || !$past(tickRise[0]))
        else $error("loop ran during global reset");
    AST_STAGE: assert property (
        $changed(alignLoop) |-> $past(tickRise[0]))
        else $error("alignment loop moved off its slice clock");
    AST_RAM_ACCESS: assert property (
        $rose(ctrl[B_ALOOP]) |-> !alignRamBusAccess)
        else $error("diagnostic RAM left open during loop");
    AST_ERR_CLEAR: assert property (
        ctrl[B_ACLR] && (sys.alignW0 & ~hitPrev[43:30]) == 14'h0
        |=> err[0] == '0)
        else $error("alignment error record not cleared");

endmodule : fbv_board_control

// ===== verif/fbv_bus_master.sv
/*
 * Crate bus master model: one 32-bit beat per call, bounded wait for DTACK.
 * Assumes the board answers within 40 clocks and pins change on falling edges.
 */
module fbv_bus_master import fbv_pkg::*; #(
    parameter logic [4:0] GA = 5'h03
) (
    input  wire logic           mclk,
    input  wire logic           vmeDtackOe,
    input  wire logic    [31:0] vmeDataOut,
    output fbv_vme_in_type      vmeIn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        vmeIn = '1;
        vmeIn.ga = GA;
    end
    task automatic xfer(input logic wr, input logic [5:0] am, input logic [31:0] a, d,
                        output logic [31:0] rd, output logic ack);
        int n;
        @(negedge mclk);
        vmeIn.addr = a[31:2];
        vmeIn.am = am;
        vmeIn.writeN = !wr;
        vmeIn.data = d;
        {vmeIn.asN, vmeIn.ds0N, vmeIn.ds1N, vmeIn.lwordN} = 4'h0;
        ack = 1'b0;
        rd = '0;
        for (n = 0; n < 40 && !ack; n++) begin
            @(posedge mclk);
            ack = vmeDtackOe;
            rd = vmeDataOut;
        end
        @(negedge mclk);
        {vmeIn.asN, vmeIn.ds0N, vmeIn.ds1N, vmeIn.lwordN} = 4'hf;
        // Released data lines must not keep the last value.
        vmeIn.data = ~d;
        for (n = 0; n < 10 && vmeDtackOe; n++) @(posedge mclk);
        @(negedge mclk);
    endtask : xfer
endmodule : fbv_bus_master

// ===== verif/tb_fbv_board_control.sv
/*
 * Testbench of the finder board control logic through its own bus protocol.
 * Assumes board address 03, so registers sit at 0x0300_0000 onward.
 */
module tb_fbv_board_control import fbv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] BASE = 32'h0300_0000;
    logic mclk = 1'b0, nrst = 1'b0, ack, alignReset, alignRamBusAccess, readyLed, errorFlag;
    logic [31:0] vmeDataOut, rdat;
    logic vmeDtackOe;
    logic [3:0] forceProgram;
    logic [7:0] clockDelay;
    logic alignLoop, finderLoop, pixelLoop, finderReset, pixelReset;
    logic flashProgEnable, swClock, clockSelect;
    fbv_vme_in_type vmeIn;
    fbv_sys_in_type sysIn;
    int errors = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    fbv_bus_master u_fbv_bus_master (.mclk(mclk), .vmeDtackOe(vmeDtackOe),
        .vmeDataOut(vmeDataOut), .vmeIn(vmeIn));
    fbv_board_control u_fbv_board_control (.mclk(mclk), .nrst(nrst), .vmeIn(vmeIn),
        .sysIn(sysIn), .vmeDataOut(vmeDataOut), .vmeDataOe(), .vmeDtackN(),
        .vmeDtackOe(vmeDtackOe), .chipOut(), .alignLoop(alignLoop),
        .finderLoop(finderLoop), .pixelLoop(pixelLoop), .alignReset(alignReset),
        .finderReset(finderReset), .pixelReset(pixelReset), .forceProgram(forceProgram),
        .flashProgEnable(flashProgEnable), .alignRamBusAccess(alignRamBusAccess),
        .swClock(swClock), .clockSelect(clockSelect), .clockDelay(clockDelay),
        .readyLed(readyLed), .errorFlag(errorFlag));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wr(input logic [31:0] a, d);
        u_fbv_bus_master.xfer(1'b1, AM_A32_SINGLE, BASE | a, d, rdat, ack);
    endtask : wr
    task automatic rdc(input string nm, input logic [31:0] a, e);
        u_fbv_bus_master.xfer(1'b0, AM_A32_BLOCK, BASE | a, '0, rdat, ack);
        check(nm, rdat, e);
    endtask : rdc
    task automatic wrap_up;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #50us;
        errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sysIn = '0;
        sysIn.done = '1;
        sysIn.haltN = 1'b1;
        repeat (4) @(negedge mclk);
        nrst = 1'b1;
        repeat (6) @(negedge mclk);
        rdc("ctrl", OFS_CTRL, 32'h0000_0ffe);
        wr(OFS_DIAG, 32'ha5c3_0f96);
        rdc("diag", OFS_DIAG, 32'ha5c3_0f96);
        wr(OFS_DEPTH, 32'h2a00_0000);
        rdc("header", 32'h0050_0000, 32'h2a5a_0103);
        wr(OFS_CLKDLY, 32'h7f00_0000);
        check("delay", 32'(clockDelay), 32'h7f);
        sysIn.alignW0[0] = 1'b1;
        repeat (6) @(negedge mclk);
        rdc("errrec", OFS_AW0, 32'h0100_0001);
        check("errflag", 32'(errorFlag), 32'h1);
        wr(OFS_CTRL, 32'hffff_ffff);
        // Bit 31 rides along, so the three loop bits read back cleared.
        rdc("ctrlall", OFS_CTRL, 32'hefdb_fffe);
        check("outs", 32'({alignReset, forceProgram, alignRamBusAccess}),
              32'h3f);
        check("rst2", 32'({finderReset, pixelReset}), 32'h3);
        check("clks", 32'({flashProgEnable, swClock, clockSelect}), 32'h7);
        rdc("errclr", OFS_AW0, 32'h0);
        wr(OFS_CTRL, 32'h0000_0000);
        check("outsclr", 32'({alignReset, forceProgram, finderReset, swClock}), 32'h0);
        wr(OFS_CTRL, 32'h1026_0000);
        sysIn.beamSync = 1'b1;
        repeat (4) @(negedge mclk);
        sysIn.ticks = 3'h7;
        repeat (4) @(negedge mclk);
        check("loops", 32'({alignLoop, finderLoop, pixelLoop}), 32'h7);
        check("ramlock", 32'(alignRamBusAccess), 32'h0);
        sysIn.globalReset = 1'b1;
        sysIn.ticks = 3'h0;
        repeat (4) @(negedge mclk);
        sysIn.ticks = 3'h7;
        repeat (4) @(negedge mclk);
        check("loopgate", 32'({alignLoop, finderLoop, pixelLoop}), 32'h0);
        sysIn.chipRdData = 32'h1357_9bdf;
        rdc("chiprd", 32'h0020_0000, 32'h1357_9bdf);
        rdc("idchar", 32'h0010_0000, 32'h3100_0000);
        u_fbv_bus_master.xfer(1'b0, 6'h0d, BASE, '0, rdat, ack);
        check("badam", 32'(ack), 32'h0);
        u_fbv_bus_master.xfer(1'b0, AM_A32_SINGLE, 32'h0400_0000, '0, rdat, ack);
        check("badga", 32'(ack), 32'h0);
        sysIn.done[0] = 1'b0;
        repeat (6) @(negedge mclk);
        check("ready", 32'(readyLed), 32'h0);
        wrap_up();
    end
endmodule : tb_fbv_board_control
